/* File: timing_io_defines.svh */
`ifndef TIMING_IO_DEFINES_SVH
`define TIMING_IO_DEFINES_SVH

`define NUM_COUNTERS 5
`define XBAR_LINES 7

`define OFS_CONTROL 8'h00
`define OFS_START 8'h04
`define OFS_CLEAR 8'h08
`define OFS_STATUS 8'h0c
`define OFS_FREQ 8'h10
`define OFS_XBAR_TRIG 8'h14
`define OFS_XBAR_BOARD 8'h18
`define OFS_CNT_BASE 8'h20
`define OFS_CNT_END 8'h48
`define CNT_SLOT_BASE 5'h04
`define CNT_SLOT_NONE 3'h7

`define CTL_WAVE 0
`define CTL_DAC_IRQ 1
`define CTL_DAC_DMA 2
`define CTL_CHAIN 3
`define CTL_FREQ_EN 4

`define FREQ_SRC_MSB 4
`define FREQ_DIV_LSB 8
`define FREQ_DIV_MSB 11
`define FREQ_DIV_FULL 5'h10

`define CONTROL_RESET 5'h00
`define CFG_RESET 12'h400
`define TB_RESET 6'h3e
`define TRIG_OE_N_RESET 7'h7f

`define DECADE_LAST 4'h9
`define DECADE_HALF 4'h5
`define SEL_PREV 5'h10
`define XBAR_SEL_NONE 3'h7

`endif

/* File: timing_io_pkg.sv */
package timing_io_pkg;

  typedef enum logic [2:0] {
    GATE_NONE,
    GATE_HIGH,
    GATE_LOW,
    GATE_RISE,
    GATE_FALL,
    GATE_NEXT_HIGH,
    GATE_PREV_HIGH
  } gate_mode_t;

  typedef enum logic [1:0] {
    OUT_TC_PULSE,
    OUT_TC_TOGGLE,
    OUT_HIGH_Z,
    OUT_DRIVE_LOW
  } out_mode_t;

  typedef struct packed {
    logic invert;
    out_mode_t out_mode;
    gate_mode_t gate_mode;
    logic falling;
    logic [4:0] src_sel;
  } counter_cfg_t;

  typedef struct packed {
    logic en;
    logic [2:0] sel;
  } xbar_route_t;

  typedef struct packed {
    logic [15:0] count;
    logic src_prev;
    logic gate_prev;
    logic run;
    logic toggle;
    logic tc;
    logic level;
    logic pin;
    logic pin_en_n;
  } counter_state_t;

  typedef struct packed {
    logic [4:0][3:0] dec_cnt;
    logic [5:0] tb;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic [4:0] control;
    logic [4:0] freq_src;
    logic [3:0] freq_div;
    logic [3:0] freq_cnt;
    logic freq_src_prev;
    logic freq_out;
    xbar_route_t [6:0] xbar_trig;
    xbar_route_t [6:0] xbar_board;
    logic [6:0] trig_out;
    logic [6:0] trig_oe_n;
    logic [6:0] board_bus;
    counter_cfg_t [4:0] cfg;
    logic [4:0][15:0] load;
    logic [4:0] load_wr;
    logic ext_trig_prev;
    logic sample_gate;
    logic scan_clock;
    logic dac_trig_prev;
    logic dac_update;
    logic dac_irq;
    logic dac_dma;
  } top_state_t;

endpackage : timing_io_pkg

/* File: count_channel.sv */
`timescale 1ns/1ns
`include "timing_io_defines.svh"

module count_channel
  import timing_io_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire counter_cfg_t i_cfg,
  input wire logic [15:0] i_load,
  input wire logic i_load_wr,
  input wire logic i_source,
  input wire logic i_gate,
  input wire logic i_gate_next,
  input wire logic i_gate_prev,
  output logic [15:0] o_count,
  output logic o_tc,
  output logic o_level,
  output logic o_pin,
  output logic o_pin_en_n
);

  counter_state_t state_reg;
  counter_state_t state_next;
  logic edge_hit;
  logic gate_ok;
  logic lvl;

  always_comb begin
    state_next = state_reg;
    edge_hit = i_cfg.falling ? (state_reg.src_prev & ~i_source)
                             : (~state_reg.src_prev & i_source);
    state_next.src_prev = i_source;
    state_next.gate_prev = i_gate;
    gate_ok = 1'b0;
    case (i_cfg.gate_mode)
      GATE_NONE: gate_ok = 1'b1;
      GATE_HIGH: gate_ok = i_gate;
      GATE_LOW: gate_ok = ~i_gate;
      GATE_RISE: begin
        gate_ok = state_reg.run;
        if (~state_reg.gate_prev & i_gate) begin
          state_next.run = 1'b1;
        end
      end
      GATE_FALL: begin
        gate_ok = state_reg.run;
        if (state_reg.gate_prev & ~i_gate) begin
          state_next.run = 1'b1;
        end
      end
      GATE_NEXT_HIGH: gate_ok = i_gate_next;
      GATE_PREV_HIGH: gate_ok = i_gate_prev;
      default: gate_ok = 1'b0;
    endcase
    state_next.tc = 1'b0;
    if (i_load_wr) begin
      state_next.count = i_load;
      state_next.run = 1'b0;
    end else if (edge_hit && gate_ok) begin
      if (state_reg.count <= 16'h0001) begin
        state_next.count = i_load;
        state_next.tc = 1'b1;
        state_next.toggle = ~state_reg.toggle;
        state_next.run = 1'b0;
      end else begin
        state_next.count = state_reg.count - 16'h0001;
      end
    end
    lvl = ((i_cfg.out_mode == OUT_TC_TOGGLE) ? state_next.toggle
                                              : state_next.tc)
          ^ i_cfg.invert;
    state_next.level = lvl;
    state_next.pin = (i_cfg.out_mode == OUT_DRIVE_LOW) ? 1'b0 : lvl;
    state_next.pin_en_n = (i_cfg.out_mode == OUT_HIGH_Z);
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= '0;
      state_reg.pin_en_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_count = state_reg.count;
  assign o_tc = state_reg.tc;
  assign o_level = state_reg.level;
  assign o_pin = state_reg.pin;
  assign o_pin_en_n = state_reg.pin_en_n;

  tc_reload_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (edge_hit && gate_ok && !i_load_wr && state_reg.count <= 16'h0001)
    |=> (state_reg.tc && state_reg.count == $past(i_load)))
    else $error("Counter did not pulse and reload at terminal count.");

  toggle_flip_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state_next.tc && i_cfg.out_mode == OUT_TC_TOGGLE)
    |=> (state_reg.toggle != $past(state_reg.toggle)))
    else $error("Toggle output did not change at terminal count.");

  out_modes_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_cfg.out_mode == OUT_DRIVE_LOW) |=> (!o_pin && !o_pin_en_n))
    else $error("Counter output not driven low when asked.");

  gate_low_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_cfg.gate_mode == GATE_LOW && i_gate && !i_load_wr)
    |=> (state_reg.count == $past(state_reg.count)))
    else $error("Counter moved while its low-level gate was closed.");

endmodule : count_channel

/* File: timing_io_counter_glue.sv */
// Contract
// - Counter main clock is board clock over ten.
// - Board clock halved on source two; six timebases.
// - Five independent 16-bit counters with source, gate, output.
// - Selectable count source and counting edge.
// - Five gating modes per counter.
// - Optional high-level gating by neighbour gate inputs.
// - Output may be high impedance or driven low.
// - Pulse mode pulses on rollover and reload.
// - Toggle mode inverts output on each rollover.
// - Pulse and toggle outputs optionally inverted.
// - Trigger fall or start strobe sets sample gate.
// - Terminal count, overflow, overrun or clear resets it.
// - Waveform mode: low pulse updates both DACs.
// - Falling update edge raises interrupt or DMA request.
// - Counters three and four serve acquisition timing.
// - Counter five chains with four, 32-bit count.
// - Scan clock feeds a source; counter one to acquisition.
// - Counter two may time each scan pass.
// - Frequency output divides selected source by 4-bit value.
// - Seven by seven trigger crossbar, fan-out both ways.
// - Counter five source comes through the crossbar.
// - Scan clock pulses once per conversion start.
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "timing_io_defines.svh"

module timing_io_counter_glue
  import timing_io_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic i_source1,
  input wire logic i_crossbar_count_source,
  input wire logic i_gate1,
  input wire logic i_gate2,
  input wire logic i_gate5,
  input wire logic i_acq_gate3,
  input wire logic i_external_trigger_n,
  input wire logic i_conversion_start,
  input wire logic i_sample_overflow,
  input wire logic i_conversion_overrun,
  input wire logic [6:0] i_trig_line,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_counter_main_clock,
  output logic [4:0] o_counter_pin,
  output logic [4:0] o_counter_pin_en_n,
  output logic o_list_pointer_source,
  output logic o_scan_interval,
  output logic o_acq_convert,
  output logic o_acq_sample,
  output logic o_sample_gate_input,
  output logic o_scan_clock,
  output logic o_frequency_output,
  output logic [6:0] o_trig_line_out,
  output logic [6:0] o_trig_line_oe_n,
  output logic o_dac_update,
  output logic o_dac_irq_req,
  output logic o_dac_dma_req
);

  top_state_t state_reg;
  top_state_t state_next;
  logic [4:0] level_w;
  logic [4:0] tc_w;
  logic [4:0][15:0] count_w;
  logic [4:0] gate_w;
  logic [4:0] source_w;
  logic crossbar_count_source;
  logic dac_update_trigger_n;
  logic [6:0] board_side;
  logic tick;
  logic wr;
  logic start_wr;
  logic clear_wr;
  logic ext_fall;
  logic sample_tc;
  logic gate_set;
  logic gate_clr;
  logic freq_src_lvl;
  logic freq_rise;
  logic [4:0] freq_divisor;
  logic dac_fall;
  logic [2:0] wslot;
  logic [2:0] rslot;

  function automatic logic pick_source(input logic [16:0] v,
                                       input logic [4:0] sel);
    pick_source = (sel > `SEL_PREV) ? 1'b0 : v[sel];
  endfunction : pick_source

  function automatic logic xbar_pick(input logic [6:0] v,
                                     input logic [2:0] sel);
    xbar_pick = (sel == `XBAR_SEL_NONE) ? 1'b0 : v[sel];
  endfunction : xbar_pick

  function automatic logic [2:0] cnt_slot(input logic [7:0] a);
    logic [4:0] w;
    w = a[7:3] - `CNT_SLOT_BASE;
    if (a >= `OFS_CNT_BASE && a < `OFS_CNT_END && a[1:0] == 2'h0) begin
      cnt_slot = w[2:0];
    end else begin
      cnt_slot = `CNT_SLOT_NONE;
    end
  endfunction : cnt_slot

  // Source two carries the halved board clock, three the scan clock.
  assign source_w = {crossbar_count_source, 1'b0, state_reg.scan_clock,
                     state_reg.tb[0], i_source1};
  assign gate_w = {i_gate5, state_reg.sample_gate, i_acq_gate3,
                   i_gate2, i_gate1};
  assign crossbar_count_source = state_reg.xbar_board[3].en
                                 ? state_reg.board_bus[3]
                                 : i_crossbar_count_source;
  assign dac_update_trigger_n = state_reg.xbar_board[6].en
                                ? state_reg.board_bus[6]
                                : 1'b1;
  assign board_side = {dac_update_trigger_n, state_reg.freq_out,
                       level_w[4], crossbar_count_source, level_w[1],
                       level_w[0], i_gate1};

  for (genvar g = 0; g < `NUM_COUNTERS; g++) begin : g_counter
    logic src_level;
    // The previous counter's output lets counter five extend counter four.
    assign src_level = pick_source({level_w[(g + 4) % `NUM_COUNTERS],
                                    gate_w, source_w, state_reg.tb},
                                   state_reg.cfg[g].src_sel);
    count_channel u_count (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_cfg(state_reg.cfg[g]),
      .i_load(state_reg.load[g]),
      .i_load_wr(state_reg.load_wr[g]),
      .i_source(src_level),
      .i_gate(gate_w[g]),
      .i_gate_next(gate_w[(g + 1) % `NUM_COUNTERS]),
      .i_gate_prev(gate_w[(g + 4) % `NUM_COUNTERS]),
      .o_count(count_w[g]),
      .o_tc(tc_w[g]),
      .o_level(level_w[g]),
      .o_pin(o_counter_pin[g]),
      .o_pin_en_n(o_counter_pin_en_n[g])
    );
  end

  always_comb begin
    state_next = state_reg;
    wr = state_reg.ph_valid & state_reg.ph_write;
    start_wr = 1'b0;
    clear_wr = 1'b0;
    wslot = `CNT_SLOT_NONE;
    rslot = `CNT_SLOT_NONE;
    // Decade chain of timebases below the halved board clock.
    state_next.tb[0] = ~state_reg.tb[0];
    tick = 1'b1;
    for (int k = 0; k < 5; k++) begin
      if (tick) begin
        state_next.dec_cnt[k] = (state_reg.dec_cnt[k] == `DECADE_LAST)
                                ? 4'h0 : state_reg.dec_cnt[k] + 4'h1;
      end
      state_next.tb[k + 1] = (state_next.dec_cnt[k] < `DECADE_HALF);
      tick = tick & (state_reg.dec_cnt[k] == `DECADE_LAST);
    end
    state_next.ph_valid = i_hsel & i_htrans[1] & i_hready &
                          (i_hsize == 3'h2);
    state_next.ph_write = i_hwrite;
    state_next.ph_addr = i_haddr[7:0];
    state_next.load_wr = '0;
    if (wr) begin
      case (state_reg.ph_addr)
        `OFS_CONTROL: state_next.control = i_hwdata[4:0];
        `OFS_START: start_wr = 1'b1;
        `OFS_CLEAR: clear_wr = 1'b1;
        `OFS_FREQ: begin
          state_next.freq_src = i_hwdata[`FREQ_SRC_MSB:0];
          state_next.freq_div = i_hwdata[`FREQ_DIV_MSB:`FREQ_DIV_LSB];
        end
        `OFS_XBAR_TRIG: state_next.xbar_trig = i_hwdata[27:0];
        `OFS_XBAR_BOARD: state_next.xbar_board = i_hwdata[27:0];
        default: begin
          wslot = cnt_slot(state_reg.ph_addr);
          if (wslot < 3'h5) begin
            if (state_reg.ph_addr[2]) begin
              state_next.load[wslot] = i_hwdata[15:0];
              state_next.load_wr[wslot] = 1'b1;
            end else begin
              state_next.cfg[wslot] = counter_cfg_t'(i_hwdata[11:0]);
            end
          end
        end
      endcase
    end
    // Sample gate: a set in the same cycle as a clear wins.
    ext_fall = state_reg.ext_trig_prev & ~i_external_trigger_n;
    state_next.ext_trig_prev = i_external_trigger_n;
    sample_tc = state_reg.control[`CTL_CHAIN] ? tc_w[4] : tc_w[3];
    gate_set = ext_fall | start_wr;
    gate_clr = sample_tc | i_sample_overflow | i_conversion_overrun |
               clear_wr;
    if (gate_set) begin
      state_next.sample_gate = 1'b1;
    end else if (gate_clr) begin
      state_next.sample_gate = 1'b0;
    end
    state_next.scan_clock = i_conversion_start;
    // Frequency output passes one source pulse in every divisor pulses.
    freq_src_lvl = pick_source({1'b0, gate_w, source_w, state_reg.tb},
                               state_reg.freq_src);
    freq_rise = ~state_reg.freq_src_prev & freq_src_lvl;
    state_next.freq_src_prev = freq_src_lvl;
    freq_divisor = (state_reg.freq_div == 4'h0) ? `FREQ_DIV_FULL
                                                : {1'b0, state_reg.freq_div};
    if (freq_rise) begin
      if ({1'b0, state_reg.freq_cnt} + 5'h01 >= freq_divisor) begin
        state_next.freq_cnt = 4'h0;
      end else begin
        state_next.freq_cnt = state_reg.freq_cnt + 4'h1;
      end
    end
    state_next.freq_out = state_reg.control[`CTL_FREQ_EN] & freq_src_lvl &
                          (state_next.freq_cnt == 4'h0);
    for (int j = 0; j < `XBAR_LINES; j++) begin
      state_next.trig_out[j] = xbar_pick(board_side,
                                         state_reg.xbar_trig[j].sel);
      state_next.trig_oe_n[j] = ~state_reg.xbar_trig[j].en;
      state_next.board_bus[j] = xbar_pick(i_trig_line,
                                          state_reg.xbar_board[j].sel);
    end
    dac_fall = state_reg.dac_trig_prev & ~dac_update_trigger_n;
    state_next.dac_trig_prev = dac_update_trigger_n;
    state_next.dac_update = dac_fall & state_reg.control[`CTL_WAVE];
    state_next.dac_irq = dac_fall & state_reg.control[`CTL_DAC_IRQ];
    state_next.dac_dma = dac_fall & state_reg.control[`CTL_DAC_DMA];
    state_next.ready = 1'b1;
    state_next.resp = 1'b0;
    state_next.rdata = 32'h0;
    if (state_next.ph_valid && !i_hwrite) begin
      case (i_haddr[7:0])
        `OFS_CONTROL: state_next.rdata = {27'h0, state_next.control};
        `OFS_STATUS: state_next.rdata = {25'h0, level_w,
                                         state_next.freq_out,
                                         state_next.sample_gate};
        `OFS_FREQ: state_next.rdata = {20'h0, state_next.freq_div, 3'h0,
                                       state_next.freq_src};
        `OFS_XBAR_TRIG: state_next.rdata = {4'h0, state_next.xbar_trig};
        `OFS_XBAR_BOARD: state_next.rdata = {4'h0, state_next.xbar_board};
        default: begin
          rslot = cnt_slot(i_haddr[7:0]);
          if (rslot < 3'h5) begin
            if (i_haddr[2]) begin
              state_next.rdata = {16'h0, count_w[rslot]};
            end else begin
              state_next.rdata = {20'h0, state_next.cfg[rslot]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= '0;
      state_reg.tb <= `TB_RESET;
      state_reg.ready <= 1'b1;
      state_reg.control <= `CONTROL_RESET;
      state_reg.trig_oe_n <= `TRIG_OE_N_RESET;
      state_reg.cfg <= {`NUM_COUNTERS{`CFG_RESET}};
      state_reg.ext_trig_prev <= 1'b1;
      state_reg.dac_trig_prev <= 1'b1;
      state_reg.sample_gate <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_hrdata = state_reg.rdata;
  assign o_hreadyout = state_reg.ready;
  assign o_hresp = state_reg.resp;
  assign o_counter_main_clock = state_reg.tb[1];
  assign o_list_pointer_source = level_w[0];
  assign o_scan_interval = level_w[1];
  assign o_acq_convert = level_w[2];
  assign o_acq_sample = level_w[3];
  assign o_sample_gate_input = state_reg.sample_gate;
  assign o_scan_clock = state_reg.scan_clock;
  assign o_frequency_output = state_reg.freq_out;
  assign o_trig_line_out = state_reg.trig_out;
  assign o_trig_line_oe_n = state_reg.trig_oe_n;
  assign o_dac_update = state_reg.dac_update;
  assign o_dac_irq_req = state_reg.dac_irq;
  assign o_dac_dma_req = state_reg.dac_dma;

  sequence main_clock_high_s;
    o_counter_main_clock [*5] ##1 !o_counter_main_clock;
  endsequence

  sequence dac_pulse_s;
    o_dac_update ##1 !o_dac_update;
  endsequence

  main_clock_div_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $rose(o_counter_main_clock) |-> main_clock_high_s)
    else $error("Counter main clock is not the board clock over ten.");

  half_clock_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $past(i_rst_b) |-> state_reg.tb[0] != $past(state_reg.tb[0]))
    else $error("Halved board clock failed to toggle.");

  gate_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    gate_set |=> o_sample_gate_input)
    else $error("Sample gate not set by trigger or start strobe.");

  gate_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (gate_clr && !gate_set) |=> !o_sample_gate_input)
    else $error("Sample gate not cleared by its clearing event.");

  dac_update_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (dac_fall && state_reg.control[`CTL_WAVE]) |=> dac_pulse_s)
    else $error("Waveform update pulse missing or too long.");

  dac_request_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (dac_fall && state_reg.control[`CTL_DAC_IRQ]) |=> o_dac_irq_req)
    else $error("Update edge raised no interrupt request.");

  scan_pulse_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_scan_clock |-> $past(i_conversion_start))
    else $error("Scan clock pulsed without a conversion start.");

  xbar_drive_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    state_reg.xbar_trig[4].en |=> !o_trig_line_oe_n[4])
    else $error("Enabled trigger line is not driven.");

  freq_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !state_reg.control[`CTL_FREQ_EN] |=> !o_frequency_output)
    else $error("Frequency output active while disabled.");

  bus_okay_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_hreadyout && !o_hresp)
    else $error("Bus slave stalled or answered with an error.");

endmodule : timing_io_counter_glue

/* File: far_side_model.sv */
`timescale 1ns/1ns
module far_side_model (
  input wire logic i_clock,
  input wire logic [6:0] i_line_out,
  input wire logic [6:0] i_line_oe_n,
  output logic o_trig_n,
  output logic o_conv,
  output logic o_ovf,
  output logic o_ovr,
  output logic [6:0] o_line
);
  logic [6:0] drive_reg;
  initial begin
    o_trig_n = 1'h1;
    o_conv = 1'h0;
    o_ovf = 1'h0;
    o_ovr = 1'h0;
    drive_reg = 7'h7f;
  end
  // Shared lines are pulled up, so a line nobody drives idles high.
  assign o_line = (~i_line_oe_n & i_line_out) | (i_line_oe_n & drive_reg);
  // The conversion start line idles low, and only event 3 raises it, for one cycle.
  // Pulse one event for one cycle: 0 trigger, 1 overflow, 2 overrun,
  // 3 conversion start, 4 to 10 pull shared line 0 to 6 low.
  task pulse(input int which);
    logic [10:0] act;
    act = 11'h1 << which;
    o_trig_n <= ~act[0];
    o_ovf <= act[1];
    o_ovr <= act[2];
    o_conv <= act[3];
    drive_reg <= ~act[10:4];
    @(posedge i_clock);
    o_trig_n <= 1'h1;
    o_ovf <= 1'h0;
    o_ovr <= 1'h0;
    o_conv <= 1'h0;
    drive_reg <= 7'h7f;
  endtask : pulse
endmodule : far_side_model

/* File: timing_io_counter_glue_test.sv */
`timescale 1ns/1ns
module timing_io_counter_glue_test;
  import timing_io_pkg::*;
  logic i_clock = 1'h0, i_rst_b = 1'h0, i_hsel = 1'h0, i_hwrite = 1'h0;
  logic i_gate1 = 1'h0, i_gate2 = 1'h0, i_source1 = 1'h0;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, rdata;
  logic [1:0] i_htrans = 2'h0;
  logic [2:0] i_hsize = 3'h2;
  logic [6:0] i_trig_line, o_trig_line_out, o_trig_line_oe_n;
  logic [4:0] o_counter_pin, o_counter_pin_en_n;
  logic i_external_trigger_n, i_conversion_start, i_sample_overflow;
  logic i_conversion_overrun, o_hreadyout, o_counter_main_clock;
  logic o_list_pointer_source, o_sample_gate_input, o_scan_clock;
  logic o_dac_update, o_dac_irq_req, o_dac_dma_req, o_frequency_output;
  wire logic i_hready;
  int fails = 0, compares = 0, n, len, k, u, q, d;
  always #20 i_clock = ~i_clock;
  assign i_hready = o_hreadyout;
  timing_io_counter_glue i_dut (.i_clock, .i_rst_b, .i_hsel, .i_haddr,
    .i_htrans, .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .i_source1,
    .i_crossbar_count_source(1'h0), .i_gate1, .i_gate2, .i_gate5(1'h0),
    .i_acq_gate3(1'h0), .i_external_trigger_n, .i_conversion_start,
    .i_sample_overflow, .i_conversion_overrun, .i_trig_line, .o_hrdata,
    .o_hreadyout, .o_hresp(), .o_counter_main_clock, .o_counter_pin,
    .o_counter_pin_en_n, .o_list_pointer_source, .o_scan_interval(),
    .o_acq_convert(), .o_acq_sample(), .o_sample_gate_input, .o_scan_clock,
    .o_frequency_output, .o_trig_line_out, .o_trig_line_oe_n,
    .o_dac_update, .o_dac_irq_req, .o_dac_dma_req);
  far_side_model far (.i_clock, .i_line_out(o_trig_line_out),
    .i_line_oe_n(o_trig_line_oe_n), .o_trig_n(i_external_trigger_n),
    .o_conv(i_conversion_start), .o_ovf(i_sample_overflow),
    .o_ovr(i_conversion_overrun), .o_line(i_trig_line));
  task final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  task check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wait_rdy;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (i_hready !== 1'h1 && n < 20);
    if (i_hready !== 1'h1) begin
      fails++;
      final_report;
    end
  endtask : wait_rdy
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_hsel <= 1'h1;
    i_haddr <= {24'h0, a};
    i_htrans <= 2'h2;
    i_hwrite <= w;
    wait_rdy;
    i_hsel <= 1'h0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    wait_rdy;
    rdata = o_hrdata;
  endtask : bus
  // Count edges until the watched level changes.
  task run_len(input bit which);
    logic v;
    v = which ? o_list_pointer_source : o_counter_main_clock;
    len = 0;
    while ((which ? o_list_pointer_source : o_counter_main_clock) === v
           && len < 40) begin
      @(posedge i_clock);
      len++;
    end
  endtask : run_len
  initial begin
    repeat (6) @(posedge i_clock);
    i_rst_b <= 1'h1;
    check("sample gate", o_sample_gate_input, 32'h0);
    check("pin enables", o_counter_pin_en_n, 32'h1f);
    bus(1'h0, 8'h20, 32'h0);
    check("config reset", rdata, 32'h400);
    bus(1'h0, 8'hfc, 32'h0);
    check("unmapped", rdata, 32'h0);
    run_len(1'h0);
    for (k = 0; k < 2; k++) begin
      run_len(1'h0);
      check("main clock run", len, 32'h5);
    end
    // Counter four is parked on a constant source so its TC stays quiet.
    bus(1'h1, 8'h38, 32'h409);
    bus(1'h1, 8'h04, 32'h0);
    @(posedge i_clock);
    check("start sets gate", o_sample_gate_input, 32'h1);
    bus(1'h0, 8'h0c, 32'h0);
    check("status gate", rdata[0], 32'h1);
    bus(1'h1, 8'h08, 32'h0);
    @(posedge i_clock);
    check("clear resets gate", o_sample_gate_input, 32'h0);
    for (k = 0; k < 3; k++) begin
      if (k > 0) begin
        bus(1'h1, 8'h04, 32'h0);
      end
      far.pulse(k);
      repeat (2) @(posedge i_clock);
      check("gate event", o_sample_gate_input, k == 0);
    end
    far.pulse(3);
    @(posedge i_clock);
    check("scan clock high", o_scan_clock, 32'h1);
    @(posedge i_clock);
    check("scan clock low", o_scan_clock, 32'h0);
    bus(1'h1, 8'h20, 32'h200);
    bus(1'h1, 8'h24, 32'h5);
    run_len(1'h1);
    run_len(1'h1);
    run_len(1'h1);
    check("toggle period", len, 32'ha);
    check("driven pin", o_counter_pin_en_n[0], 32'h0);
    bus(1'h1, 8'h20, 32'h340);
    bus(1'h1, 8'h24, 32'h5);
    repeat (4) @(posedge i_clock);
    bus(1'h0, 8'h24, 32'h0);
    check("next gate shut", rdata, 32'h5);
    i_gate2 <= 1'h1;
    repeat (4) @(posedge i_clock);
    bus(1'h0, 8'h24, 32'h0);
    check("next gate open", rdata < 32'h5, 32'h1);
    bus(1'h1, 8'h20, 32'h600);
    repeat (3) @(posedge i_clock);
    check("low pin", {o_counter_pin_en_n[0], o_counter_pin[0]}, 32'h0);
    bus(1'h1, 8'h14, 32'h00880000);
    repeat (2) @(posedge i_clock);
    check("line enables", o_trig_line_oe_n, 32'h4f);
    for (k = 1; k >= 0; k--) begin
      i_gate1 <= k[0];
      repeat (3) @(posedge i_clock);
      check("fan-out", o_trig_line_out[5:4], {2{k[0]}});
    end
    bus(1'h1, 8'h18, 32'h0a000000);
    for (k = 0; k < 3; k++) begin
      bus(1'h1, 8'h00, k == 0 ? 32'h3 : k == 1 ? 32'h5 : 32'h0);
      far.pulse(6);
      u = 0;
      q = 0;
      d = 0;
      repeat (5) begin
        @(posedge i_clock);
        u += o_dac_update;
        q += o_dac_irq_req;
        d += o_dac_dma_req;
      end
      check("dac update", u, k < 2);
      check("dac irq", q, k == 0);
      check("dac dma", d, k == 1);
    end
    bus(1'h1, 8'h10, 32'h206);
    bus(1'h1, 8'h00, 32'h10);
    u = 0;
    repeat (8) begin
      i_source1 <= 1'h1;
      @(posedge i_clock);
      u += o_frequency_output;
      i_source1 <= 1'h0;
      @(posedge i_clock);
      u += o_frequency_output;
    end
    check("freq pulses", u, 32'h4);
    final_report;
  end
endmodule : timing_io_counter_glue_test
